// ==== common/psbs_cfg.svh ====
`ifndef PSBS_CFG_SVH
`define PSBS_CFG_SVH

// ****************
// widths and depth
// ****************
`define PSBS_ADDR_W 19
`define PSBS_DATA_W 32
`define PSBS_LANES 4
`define PSBS_LANE_W 8
`define PSBS_DEPTH 524288

// ***************************
// burst counter and lane sets
// ***************************
`define PSBS_CNT_W 2
`define PSBS_CNT_ZERO 2'h0
`define PSBS_CNT_ONE 2'h1
`define PSBS_LOW_MSB 1
`define PSBS_HIGH_LSB 2
`define PSBS_ALL_LANES 4'hf
`define PSBS_NO_LANES 4'h0

`endif

// ==== common/psbs_pkg.sv ====
`default_nettype none
`include "psbs_cfg.svh"

package psbs_pkg;

  // ***************************
  // synchronous control strobes
  // ***************************
  typedef struct packed {
    logic cpu_addr_strobe_n;
    logic ctl_addr_strobe_n;
    logic chip_sel_low_a;
    logic chip_sel_high;
    logic chip_sel_low_b;
    logic burst_step_n;
    logic global_write_n;
    logic byte_write_qualifier_n;
    logic [`PSBS_LANES-1:0] byte_lane_select_n;
  } psbs_ctl_type;

  // *************************
  // one stored word with lanes
  // *************************
  typedef struct packed {
    logic [`PSBS_LANES-1:0] parity;
    logic [`PSBS_DATA_W-1:0] data;
  } psbs_word_type;

  // ************
  // port states
  // ************
  typedef enum logic [2:0] {
    PSBS_IDLE  = 3'h1,
    PSBS_BURST = 3'h2,
    PSBS_SLEEP = 3'h4
  } psbs_state_type;

endpackage : psbs_pkg

`default_nettype wire

// ==== rtl/psbs_port.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "psbs_cfg.svh"

module psbs_port
  import psbs_pkg::*;
#(
  parameter bit HAS_THIRD_SEL = 1'b1
)
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire psbs_ctl_type ctl_in,
  input wire logic [`PSBS_ADDR_W-1:0] addr_in,
  input wire logic [`PSBS_DATA_W-1:0] data_in,
  input wire logic [`PSBS_LANES-1:0] parity_in,
  input wire logic out_drive_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic burst_order_in,
  output logic [`PSBS_DATA_W-1:0] data_out,
  output logic [`PSBS_LANES-1:0] parity_out,
  output logic data_oe_out,
  output logic parity_oe_out
);

  // *********
  // functions
  // *********
  function automatic logic [`PSBS_CNT_W-1:0] burst_low(
    input logic [`PSBS_CNT_W-1:0] start,
    input logic [`PSBS_CNT_W-1:0] cnt,
    input logic interleaved
  );
    if (interleaved)
    begin
      burst_low = start ^ cnt;
    end
    else
    begin
      burst_low = start + cnt;
    end
  endfunction

  function automatic psbs_word_type merge_lanes(
    input psbs_word_type old_word,
    input psbs_word_type new_word,
    input logic [`PSBS_LANES-1:0] lanes
  );
    psbs_word_type res;
    res = old_word;
    for (int i = 0; i < `PSBS_LANES; i++)
    begin
      if (lanes[i])
      begin
        res.data[i*`PSBS_LANE_W +: `PSBS_LANE_W] =
          new_word.data[i*`PSBS_LANE_W +: `PSBS_LANE_W];
        res.parity[i] = new_word.parity[i];
      end
    end
    merge_lanes = res;
  endfunction

  // ************
  // declarations
  // ************
  psbs_word_type mem_q [0:`PSBS_DEPTH-1];
  psbs_state_type state_q, state_d;
  logic sleep_s1_q, sleep_s2_q, order_s1_q, order_s2_q;
  logic [`PSBS_ADDR_W-1:0] base_q;
  logic [`PSBS_CNT_W-1:0] cnt_q;
  logic cpu_q;
  psbs_word_type din_q;
  logic pend_q;
  logic [`PSBS_ADDR_W-1:0] pend_addr_q;
  logic [`PSBS_LANES-1:0] pend_lanes_q;
  psbs_word_type out_q;
  logic drive_q, drive_d, sel_b_n, selected;
  logic cpu_take, ctl_take, load, in_burst, wr_now;
  logic [`PSBS_LANES-1:0] wr_lanes;
  logic [`PSBS_ADDR_W-1:0] cur_addr;
  logic [`PSBS_ADDR_W-1:0] wr_addr;
  psbs_word_type rd_word;

  // ***********
  // input sync
  // ***********
  always_ff @(posedge clock_in)
  begin
    sleep_s1_q <= sleep_request_in;
    sleep_s2_q <= sleep_s1_q;
    order_s1_q <= burst_order_in;
    order_s2_q <= order_s1_q;
  end

  // ***************
  // access decoding
  // ***************
  assign sel_b_n = HAS_THIRD_SEL ? ctl_in.chip_sel_low_b : 1'b0;
  assign selected = ~ctl_in.chip_sel_low_a & ctl_in.chip_sel_high &
                    ~sel_b_n;
  assign cpu_take = ~ctl_in.cpu_addr_strobe_n &
                    ~ctl_in.chip_sel_low_a;
  assign ctl_take = ~ctl_in.ctl_addr_strobe_n & ~cpu_take;
  assign load = (cpu_take | ctl_take) & ~sleep_s2_q;
  assign in_burst = (state_q == PSBS_BURST);
  assign cur_addr = {base_q[`PSBS_ADDR_W-1:`PSBS_HIGH_LSB],
                     burst_low(base_q[`PSBS_LOW_MSB:0], cnt_q,
                               order_s2_q)};

  // ************
  // write decode
  // ************
  assign wr_lanes = ~ctl_in.global_write_n ? `PSBS_ALL_LANES :
                    (~ctl_in.byte_write_qualifier_n ?
                     ~ctl_in.byte_lane_select_n : `PSBS_NO_LANES);

  assign wr_now = ~sleep_s2_q & (wr_lanes != `PSBS_NO_LANES) &
                  ((in_burst & ~load) | (ctl_take & selected));
  assign wr_addr = ctl_take ? addr_in : cur_addr;

  // ************
  // state machine
  // ************
  always_comb
  begin
    case (state_q)
      PSBS_IDLE, PSBS_SLEEP:
      begin
        state_d = (load & selected) ? PSBS_BURST : PSBS_IDLE;
      end
      PSBS_BURST:
      begin
        state_d = (load & ~selected) ? PSBS_IDLE : PSBS_BURST;
      end
      default:
      begin
        state_d = PSBS_IDLE;
      end
    endcase
    if (sleep_s2_q)
    begin
      state_d = PSBS_SLEEP;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (~rst_n_in)
    begin
      state_q <= PSBS_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ***********************
  // address and burst count
  // ***********************
  always_ff @(posedge clock_in)
  begin
    if (~rst_n_in)
    begin
      base_q <= '0;
      cnt_q <= `PSBS_CNT_ZERO;
      cpu_q <= 1'b0;
    end
    else if (load & selected)
    begin
      base_q <= addr_in;
      cnt_q <= `PSBS_CNT_ZERO;
      cpu_q <= cpu_take;
    end
    else if (in_burst & ~sleep_s2_q & ~ctl_in.burst_step_n)
    begin
      cnt_q <= cnt_q + `PSBS_CNT_ONE;
    end
  end

  // ********************
  // data capture, writes
  // ********************
  always_ff @(posedge clock_in)
  begin
    din_q <= {parity_in, data_in};
  end

  always_ff @(posedge clock_in)
  begin
    if (~rst_n_in)
    begin
      pend_q <= 1'b0;
      pend_addr_q <= '0;
      pend_lanes_q <= `PSBS_NO_LANES;
    end
    else
    begin
      pend_q <= wr_now;
      pend_addr_q <= wr_addr;
      pend_lanes_q <= wr_lanes;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (pend_q)
    begin
      mem_q[pend_addr_q] <= merge_lanes(mem_q[pend_addr_q], din_q,
                                        pend_lanes_q);
    end
  end

  // *********
  // read path
  // *********
  always_comb
  begin
    rd_word = mem_q[cur_addr];
    if (pend_q && (pend_addr_q == cur_addr))
    begin
      rd_word = merge_lanes(rd_word, din_q, pend_lanes_q);
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (~rst_n_in)
    begin
      out_q <= '0;
    end
    else if (in_burst & ~wr_now)
    begin
      out_q <= rd_word;
    end
  end

  // ***************
  // output control
  // ***************
  always_comb
  begin
    if (sleep_s2_q | wr_now)
    begin
      drive_d = 1'b0;
    end
    else if (load & ~in_burst)
    begin
      drive_d = 1'b0;
    end
    else if (load & ~selected)
    begin
      drive_d = drive_q;
    end
    else
    begin
      drive_d = in_burst;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (~rst_n_in)
    begin
      drive_q <= 1'b0;
    end
    else
    begin
      drive_q <= drive_d;
    end
  end

  assign data_out = out_q.data;
  assign parity_out = out_q.parity;
  assign data_oe_out = drive_q & ~out_drive_enable_n_in & ~wr_now;
  assign parity_oe_out = drive_q & ~out_drive_enable_n_in & ~wr_now;

  // **********
  // assertions
  // **********
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (~rst_n_in);

  sequence desel_seq;
    drive_q && in_burst && load && !selected && !wr_now && !sleep_s2_q;
  endsequence

  sequence lag_seq;
    drive_q ##1 !drive_q;
  endsequence

  chk_addr_capture: assert property (
    (load && selected) |=> (base_q == $past(addr_in)) && in_burst)
    else $error("address not captured on accepted strobe");

  chk_cpu_priority: assert property (
    (!ctl_in.cpu_addr_strobe_n && !ctl_in.ctl_addr_strobe_n &&
     selected && !sleep_s2_q) |=> cpu_q)
    else $error("processor strobe lost priority");

  chk_cpu_ignored: assert property (
    (ctl_in.chip_sel_low_a && ctl_in.ctl_addr_strobe_n && !sleep_s2_q &&
     state_q != PSBS_SLEEP) |=> $stable(base_q) && $stable(state_q))
    else $error("processor strobe acted while deselected");

  chk_select_decode: assert property (
    (load && !selected) |=> state_q == PSBS_IDLE)
    else $error("unselected load did not deselect");

  chk_burst_hold: assert property (
    (in_burst && !load && ctl_in.burst_step_n) |=> $stable(cnt_q))
    else $error("burst address moved without step");

  chk_burst_step: assert property (
    (in_burst && !load && !ctl_in.burst_step_n && !sleep_s2_q) |=>
    cnt_q == $past(cnt_q) + `PSBS_CNT_ONE)
    else $error("burst counter did not advance");

  chk_write_quiet: assert property (
    wr_now |-> !data_oe_out ##1 !drive_q)
    else $error("data pins driven during write");

  chk_first_read: assert property (
    (load && selected && !in_burst) |=> !drive_q)
    else $error("outputs driven in first read cycle");

  chk_deselect_lag: assert property (
    desel_seq |=> lag_seq)
    else $error("deselect tristate timing wrong");

  chk_burst_start: assert property (
    (in_burst && cnt_q == `PSBS_CNT_ZERO) |->
    cur_addr == base_q)
    else $error("burst does not start at captured address");

endmodule // psbs_port

`default_nettype wire

// ==== dv/psbs_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "psbs_cfg.svh"

module psbs_host_model
  import psbs_pkg::*;
(
  input wire logic clock_in,
  input wire logic [`PSBS_DATA_W-1:0] dev_data_in,
  input wire logic [`PSBS_LANES-1:0] dev_parity_in,
  input wire logic dev_oe_in,
  output var psbs_ctl_type ctl_out,
  output logic [`PSBS_ADDR_W-1:0] addr_out,
  output var psbs_word_type bus_out,
  output logic oe_n_out
);
  // ***************
  // data pin level
  // ***************
  psbs_word_type drv;
  psbs_word_type last_q = '0;
  logic host_en = 1'b0;

  always_comb
  begin
    if (host_en)
      bus_out = drv;
    else if (dev_oe_in)
      bus_out = {dev_parity_in, dev_data_in};
    else
      bus_out = ~last_q;
  end

  always @(posedge clock_in)
    last_q <= bus_out;

  initial
  begin
    ctl_out = 12'hd7f;
    addr_out = '0;
    oe_n_out = 1'b1;
  end

  // *************
  // one bus cycle
  // *************
  task automatic cyc(input psbs_ctl_type c,
    input logic [`PSBS_ADDR_W-1:0] a, input psbs_word_type w,
    input logic hd, input logic oe_n);
  begin
    ctl_out = c;
    addr_out = a;
    drv = w;
    host_en = hd;
    oe_n_out = oe_n;
    @(posedge clock_in);
    #1;
  end
  endtask
endmodule // psbs_host_model
`default_nettype wire

// ==== dv/psbs_port_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "psbs_cfg.svh"

module psbs_port_tb
  import psbs_pkg::*;
;
  localparam psbs_ctl_type ctl_idle = 12'hd7f;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic order = 1'b1;
  logic sleep = 1'b0;
  psbs_ctl_type ctl;
  logic [`PSBS_ADDR_W-1:0] addr;
  psbs_word_type bus;
  psbs_word_type mem [int];
  logic oe_n, doe, poe;
  logic [`PSBS_DATA_W-1:0] dout;
  logic [`PSBS_LANES-1:0] pout;
  int n_fail = 0;
  int n_checks = 0;

  psbs_port #(.HAS_THIRD_SEL(1'b1)) uut (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .ctl_in(ctl), .addr_in(addr),
    .data_in(bus.data), .parity_in(bus.parity),
    .out_drive_enable_n_in(oe_n), .sleep_request_in(sleep),
    .burst_order_in(order), .data_out(dout), .parity_out(pout),
    .data_oe_out(doe), .parity_oe_out(poe));
  psbs_host_model host (.clock_in(clock_in), .dev_data_in(dout),
    .dev_parity_in(pout), .dev_oe_in(doe), .ctl_out(ctl),
    .addr_out(addr), .bus_out(bus), .oe_n_out(oe_n));

  initial
  begin
    forever #10 clock_in = ~clock_in;
  end

  // *************
  // compare tasks
  // *************
  task automatic chk_w(input psbs_word_type exp);
  begin
    n_checks++;
    if ({pout, dout} !== exp)
    begin
      n_fail++;
      $display("unexpected %0t data %h want %h", $time, {pout, dout}, exp);
    end
  end
  endtask

  task automatic chk_oe(input logic exp);
  begin
    n_checks++;
    if (doe !== exp || poe !== exp)
    begin
      n_fail++;
      $display("unexpected %0t drive %b %b want %b", $time, doe, poe, exp);
    end
  end
  endtask

  task automatic wrap_up;
  begin
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask

  // ***********
  // bus helpers
  // ***********
  task automatic idle(input int n);
  begin
    repeat (n) host.cyc(ctl_idle, '0, '0, 1'b0, 1'b1);
  end
  endtask

  task automatic wr(input logic [18:0] a, input psbs_word_type w,
    input logic [3:0] ln, input logic g, input logic q);
    psbs_ctl_type c;
  begin
    c = ctl_idle;
    c.ctl_addr_strobe_n = 1'b0;
    c.global_write_n = ~g;
    c.byte_write_qualifier_n = ~q;
    c.byte_lane_select_n = ln;
    host.cyc(c, a, w, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++)
      if (g || (q && !ln[i]))
      begin
        mem[a].data[8*i+:8] = w.data[8*i+:8];
        mem[a].parity[i] = w.parity[i];
      end
  end
  endtask

  task automatic rd(input logic [18:0] a, input logic cpu, input int n,
    input logic lin);
    psbs_ctl_type c;
  begin
    c = ctl_idle;
    c.ctl_addr_strobe_n = 1'b0;
    c.chip_sel_high = 1'b0;
    host.cyc(c, '0, '0, 1'b0, 1'b0);
    c = ctl_idle;
    if (cpu)
      c.cpu_addr_strobe_n = 1'b0;
    else
      c.ctl_addr_strobe_n = 1'b0;
    host.cyc(c, a, '0, 1'b0, 1'b0);
    chk_oe(1'b0);
    c = ctl_idle;
    c.burst_step_n = 1'b0;
    for (int k = 0; k < n; k++)
    begin
      host.cyc(c, a, '0, 1'b0, 1'b0);
      chk_oe(1'b1);
      chk_w(mem[{a[18:2], lin ? a[1:0] + 2'(k) : a[1:0] ^ 2'(k)}]);
    end
  end
  endtask

  // *********
  // scenarios
  // *********
  task automatic s_fill;
  begin
    for (int i = 0; i < 4; i++)
      wr(19'h100 + 19'(i), {4'(9 + i), 32'h8421_0f00 + i}, 4'hf, 1, 0);
  end
  endtask

  task automatic s_burst;
    psbs_ctl_type c;
  begin
    rd(19'h102, 1'b0, 4, 1'b0);
    host.cyc(ctl_idle, '0, '0, 1'b0, 1'b0);
    chk_w(mem[19'h102]);
    host.cyc(ctl_idle, '0, '0, 1'b0, 1'b0);
    chk_w(mem[19'h102]);
    host.cyc(ctl_idle, '0, '0, 1'b0, 1'b1);
    chk_oe(1'b0);
    c = ctl_idle;
    c.global_write_n = 1'b0;
    host.cyc(c, '0, 36'h5_a5a5_1234, 1'b1, 1'b0);
    chk_oe(1'b0);
    mem[19'h102] = 36'h5_a5a5_1234;
    host.cyc(ctl_idle, '0, '0, 1'b0, 1'b0);
    chk_w(mem[19'h102]);
  end
  endtask

  task automatic s_bytes;
  begin
    wr(19'h101, 36'ha_7e3c_91d5, 4'b1010, 0, 1);
    wr(19'h101, 36'h0, 4'h0, 0, 0);
    rd(19'h101, 1'b1, 1, 1'b0);
  end
  endtask

  task automatic s_desel;
    psbs_ctl_type c;
  begin
    for (int i = 0; i < 3; i++)
    begin
      rd(19'h100, 1'b0, 1, 1'b0);
      c = ctl_idle ^ (12'h200 >> i);
      c.burst_step_n = 1'b0;
      host.cyc(c, '0, '0, 1'b0, 1'b0);
      chk_oe(1'b1);
      chk_w(mem[19'h101]);
      c.burst_step_n = 1'b1;
      c.ctl_addr_strobe_n = 1'b0;
      host.cyc(c, '0, '0, 1'b0, 1'b0);
      chk_oe(1'b1);
      host.cyc(ctl_idle, '0, '0, 1'b0, 1'b0);
      chk_oe(1'b0);
    end
  end
  endtask

  task automatic s_strobe;
    psbs_ctl_type c;
  begin
    rd(19'h102, 1'b1, 1, 1'b0);
    c = ctl_idle;
    c.cpu_addr_strobe_n = 1'b0;
    c.chip_sel_low_a = 1'b1;
    host.cyc(c, 19'h100, '0, 1'b0, 1'b0);
    chk_w(mem[19'h103]);
    host.cyc(ctl_idle, '0, '0, 1'b0, 1'b0);
    chk_oe(1'b1);
    c = ctl_idle;
    c.cpu_addr_strobe_n = 1'b0;
    c.ctl_addr_strobe_n = 1'b0;
    c.global_write_n = 1'b0;
    host.cyc(c, 19'h100, 36'h3_0bad_0bad, 1'b1, 1'b1);
    host.cyc(ctl_idle, '0, '0, 1'b0, 1'b0);
    chk_w(mem[19'h100]);
  end
  endtask

  task automatic s_sleep;
  begin
    rd(19'h100, 1'b0, 1, 1'b0);
    sleep = 1'b1;
    repeat (4) host.cyc(ctl_idle, '0, '0, 1'b0, 1'b0);
    chk_oe(1'b0);
    sleep = 1'b0;
    idle(3);
    rd(19'h100, 1'b0, 1, 1'b0);
  end
  endtask

  task automatic s_linear;
  begin
    order = 1'b0;
    rst_n_in = 1'b0;
    idle(8);
    rst_n_in = 1'b1;
    idle(1);
    rd(19'h101, 1'b0, 4, 1'b1);
  end
  endtask

  initial
  begin
    #100000;
    n_fail++;
    wrap_up;
  end

  initial
  begin
    idle(8);
    rst_n_in = 1'b1;
    idle(1);
    s_fill;
    s_burst;
    s_bytes;
    s_desel;
    s_strobe;
    s_sleep;
    s_linear;
    wrap_up;
  end
endmodule // psbs_port_tb
`default_nettype wire
